// *** core/ams_pkg.sv ***
package ams_pkg;

  // System clock and internal oscillator rates
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned OSC_HZ = 76_800;
  // Half period of the internal oscillator in system cycles, rounded down
  localparam int unsigned OSC_HALF_CYC = SYS_CLK_HZ / (2 * OSC_HZ);
  localparam logic [8:0] OSC_HALF_LAST = 9'(OSC_HALF_CYC - 1);
  localparam logic [8:0] OSC_CNT_ZERO = 9'h000;

  // Register indices; byte address is four times the index
  localparam logic [5:0] REG_STATUS_IDX = 6'h00;
  localparam logic [5:0] REG_CTRL_IDX = 6'h01;
  localparam logic [5:0] REG_RESULT_IDX = 6'h02;
  localparam logic [7:0] ADDR_STATUS = {REG_STATUS_IDX, 2'h0};
  localparam logic [7:0] ADDR_CTRL = {REG_CTRL_IDX, 2'h0};
  localparam logic [7:0] ADDR_RESULT = {REG_RESULT_IDX, 2'h0};

  // Control register field positions
  localparam int CTRL_CLK_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_RATIO_BIT = 6;

  // Reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] CLK_SEL_RESET = 2'h0;
  localparam logic RATIO_RESET = 1'b0;
  localparam logic [23:0] RESULT_RESET = 24'h000000;

  // Operating mode codes
  localparam logic [3:0] MODE_CONT = 4'h0;
  localparam logic [3:0] MODE_SINGLE = 4'h1;
  localparam logic [3:0] MODE_STANDBY = 4'h2;
  localparam logic [3:0] MODE_PDOWN = 4'h3;
  localparam logic [3:0] MODE_IDLE = 4'h4;
  localparam logic [3:0] MODE_CAL_INT_ZERO = 4'h5;
  localparam logic [3:0] MODE_CAL_INT_FULL = 4'h6;
  localparam logic [3:0] MODE_CAL_SYS_ZERO = 4'h7;
  localparam logic [3:0] MODE_CAL_SYS_FULL = 4'h8;
  localparam logic [3:0] MODE_DUTY = 4'h9;
  localparam logic [3:0] MODE_SYNC_IDLE = 4'ha;
  localparam logic [3:0] MODE_SYNC_LOW_POWER_HOLD = 4'hb;

  // Master clock select codes
  localparam logic [1:0] CLK_INT_OFF = 2'h0;
  localparam logic [1:0] CLK_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_EXT_FULL = 2'h2;
  localparam logic [1:0] CLK_EXT_HALF = 2'h3;

  // Duty cycle standby multiples: standby = active * (2^shift - 1)
  localparam int RATIO_QUARTER_SHIFT = 2;
  localparam int RATIO_SIXTEENTH_SHIFT = 4;

  // Counter widths and limits
  localparam logic [19:0] MEAS_MAX = 20'hfffff;
  localparam logic [19:0] MEAS_ZERO = 20'h00000;
  localparam logic [23:0] REST_ZERO = 24'h000000;
  localparam logic [23:0] REST_ONE = 24'h000001;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states, Gray coded along idle, run, rest
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RUN = 3'h1,
    ST_REST = 3'h3,
    ST_CAL = 3'h2,
    ST_PDOWN = 3'h6,
    ST_LOW_POWER_HOLD = 3'h7
  } ams_state_type;

endpackage : ams_pkg

// *** core/ams_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser for asynchronous pin inputs
module ams_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_reg;

  // Both stages reset low so no false edge appears at release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ams_sync

`default_nettype wire

// *** core/ams_sequencer.sv ***
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Power-down only from standby, else continuous
// - Idle holds filter, modulator in reset
// - Internal offset calibration, then idle
// - Internal gain calibration, then idle
// - System offset calibration, then idle
// - System gain calibration, then idle
// - Duty cycling alternates sequence and standby
// - Sync falling edge runs sequence, idle between
// - Sync falling edge runs sequence, standby between
// - Select 00: internal oscillator, pin undriven
// - Select 01: internal oscillator driven on pin
// - Select 10: pin clock used undivided
// - Select 11: pin clock divided by two
// - Latest result kept in 24-bit register
// - Ratio bit picks quarter or sixteenth active
// - Standby derived from measured conversion time
module ams_sequencer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic sync_n,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  // Converter core handshake, same clock
  input wire logic conv_done,
  input wire logic [23:0] conv_data,
  input wire logic seq_done,
  input wire logic cal_done,
  // Control outputs to converter core
  output logic filter_hold,
  output logic conv_run,
  output logic low_power_hold,
  output logic power_down,
  output logic cal_active,
  output logic [1:0] cal_select,
  output logic mclk_tick,
  output logic mclk_ext
);

  // Software-visible control
  logic [3:0] mode_reg;
  logic [1:0] clk_sel_reg;
  logic ratio_reg;
  logic [23:0] result_reg;
  // Sequencer state and counters
  ams_pkg::ams_state_type state_reg;
  logic [19:0] meas_reg;
  logic [23:0] rest_reg;
  // Write channel holding registers
  logic aw_held_reg;
  logic [7:0] awaddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_do;
  logic wr_ctrl;
  // Pin synchronisers and edge detection
  logic [1:0] pins_sync;
  logic sync_d_reg;
  logic clkp_d_reg;
  logic sync_fall;
  logic clkp_rise;
  // Oscillator and divider
  logic [8:0] osc_cnt_reg;
  logic osc_level_reg;
  logic osc_rise;
  logic div_reg;
  logic tick_next;
  // Derived values
  logic [23:0] meas_ext;
  logic [23:0] rest_load;
  logic [3:0] wr_mode;
  logic [31:0] rd_data;
  logic rd_ok;

  // Both pins come from outside the clock domain
  ams_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({sync_n, clk_pin_in}),
    .sync_out(pins_sync)
  );

  // Edge detection runs on the synchronised copies only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_d_reg <= 1'b0;
      clkp_d_reg <= 1'b0;
    end
    else
    begin
      sync_d_reg <= pins_sync[1];
      clkp_d_reg <= pins_sync[0];
    end
  end

  assign sync_fall = sync_d_reg & ~pins_sync[1];
  assign clkp_rise = ~clkp_d_reg & pins_sync[0];

  // Internal 76.8 kHz oscillator built from the system clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_cnt_reg <= ams_pkg::OSC_CNT_ZERO;
      osc_level_reg <= 1'b0;
    end
    else if (osc_cnt_reg == ams_pkg::OSC_HALF_LAST)
    begin
      osc_cnt_reg <= ams_pkg::OSC_CNT_ZERO;
      osc_level_reg <= ~osc_level_reg;
    end
    else
    begin
      osc_cnt_reg <= osc_cnt_reg + 9'h001;
    end
  end

  assign osc_rise = (osc_cnt_reg == ams_pkg::OSC_HALF_LAST) && !osc_level_reg;

  // Master clock source selection; tick marks each master clock rising edge
  always_comb
  begin
    tick_next = 1'b0;
    unique case (clk_sel_reg)
      ams_pkg::CLK_INT_OFF: tick_next = osc_rise;
      ams_pkg::CLK_INT_OUT: tick_next = osc_rise;
      ams_pkg::CLK_EXT_FULL: tick_next = clkp_rise;
      ams_pkg::CLK_EXT_HALF: tick_next = clkp_rise & div_reg;
    endcase
  end

  // Divide-by-two flop counts pin rising edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_reg <= 1'b0;
    else if (clk_sel_reg != ams_pkg::CLK_EXT_HALF)
      div_reg <= 1'b0;
    else if (clkp_rise)
      div_reg <= ~div_reg;
  end

  // Clock pin drive and master tick outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mclk_tick <= 1'b0;
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b0;
      mclk_ext <= 1'b0;
    end
    else
    begin
      mclk_tick <= tick_next;
      clk_pin_out <= osc_level_reg;
      // Pin is driven only when the internal clock is offered outside
      clk_pin_oe <= (clk_sel_reg == ams_pkg::CLK_INT_OUT);
      mclk_ext <= clk_sel_reg[1];
    end
  end

  // Write address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (wr_do)
      aw_held_reg <= 1'b0;
    else if (!aw_held_reg && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  // Write data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (wr_do)
      w_held_reg <= 1'b0;
    else if (!w_held_reg && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  // Write commits once address and data are both held
  assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ctrl = wr_do && (awaddr_reg == ams_pkg::ADDR_CTRL) && wstrb_reg[0];
  assign wr_mode = wdata_reg[ams_pkg::CTRL_MODE_LSB +: 4];

  // Write response; the read-only result ignores writes without error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ams_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      if ((awaddr_reg == ams_pkg::ADDR_CTRL) || (awaddr_reg == ams_pkg::ADDR_RESULT)
          || (awaddr_reg == ams_pkg::ADDR_STATUS))
        s_axi_bresp <= ams_pkg::RESP_OKAY;
      else
        s_axi_bresp <= ams_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ams_pkg::ADDR_STATUS: rd_data = {24'h000000, cal_active, conv_run, filter_hold,
                                       power_down, low_power_hold, state_reg};
      ams_pkg::ADDR_CTRL: rd_data = {25'h0000000, ratio_reg, mode_reg, clk_sel_reg};
      ams_pkg::ADDR_RESULT: rd_data = {8'h00, result_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ams_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? ams_pkg::RESP_OKAY : ams_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Clock select and ratio bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sel_reg <= ams_pkg::CLK_SEL_RESET;
      ratio_reg <= ams_pkg::RATIO_RESET;
    end
    else if (wr_ctrl)
    begin
      clk_sel_reg <= wdata_reg[ams_pkg::CTRL_CLK_LSB +: 2];
      ratio_reg <= wdata_reg[ams_pkg::CTRL_RATIO_BIT];
    end
  end

  // Latest conversion result overwrites the previous one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_reg <= ams_pkg::RESULT_RESET;
    else if (conv_done)
      result_reg <= conv_data;
  end

  // Standby length is a multiple of the measured active time
  assign meas_ext = {4'h0, meas_reg};
  assign rest_load = ratio_reg ? ((meas_ext << ams_pkg::RATIO_SIXTEENTH_SHIFT) - meas_ext)
                               : ((meas_ext << ams_pkg::RATIO_QUARTER_SHIFT) - meas_ext);

  // Mode sequencer; a mode write always takes priority over core events
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= ams_pkg::MODE_RESET;
      state_reg <= ams_pkg::ST_RUN;
    end
    else if (wr_ctrl)
    begin
      mode_reg <= wr_mode;
      unique case (wr_mode)
        ams_pkg::MODE_CONT, ams_pkg::MODE_SINGLE, ams_pkg::MODE_DUTY: state_reg <= ams_pkg::ST_RUN;
        ams_pkg::MODE_STANDBY: state_reg <= ams_pkg::ST_LOW_POWER_HOLD;
        ams_pkg::MODE_PDOWN:
        begin
          // Guard against an accidental drop into power-down
          if (state_reg == ams_pkg::ST_LOW_POWER_HOLD)
            state_reg <= ams_pkg::ST_PDOWN;
          else
          begin
            state_reg <= ams_pkg::ST_RUN;
            mode_reg <= ams_pkg::MODE_CONT;
          end
        end
        ams_pkg::MODE_IDLE: state_reg <= ams_pkg::ST_IDLE;
        ams_pkg::MODE_CAL_INT_ZERO, ams_pkg::MODE_CAL_INT_FULL,
        ams_pkg::MODE_CAL_SYS_ZERO, ams_pkg::MODE_CAL_SYS_FULL: state_reg <= ams_pkg::ST_CAL;
        ams_pkg::MODE_SYNC_IDLE, ams_pkg::MODE_SYNC_LOW_POWER_HOLD: state_reg <= ams_pkg::ST_REST;
        // Reserved codes park the converter in idle
        default: state_reg <= ams_pkg::ST_IDLE;
      endcase
    end
    else
    begin
      unique case (state_reg)
        ams_pkg::ST_CAL:
        begin
          if (cal_done)
          begin
            state_reg <= ams_pkg::ST_IDLE;
            mode_reg <= ams_pkg::MODE_IDLE;
          end
        end
        ams_pkg::ST_RUN:
        begin
          if (seq_done && (mode_reg == ams_pkg::MODE_SINGLE))
            state_reg <= ams_pkg::ST_IDLE;
          else if (seq_done && ((mode_reg == ams_pkg::MODE_DUTY) || (mode_reg == ams_pkg::MODE_SYNC_IDLE)
                   || (mode_reg == ams_pkg::MODE_SYNC_LOW_POWER_HOLD)))
            state_reg <= ams_pkg::ST_REST;
        end
        ams_pkg::ST_REST:
        begin
          if ((mode_reg == ams_pkg::MODE_DUTY) && (rest_reg == ams_pkg::REST_ZERO))
            state_reg <= ams_pkg::ST_RUN;
          else if ((mode_reg != ams_pkg::MODE_DUTY) && sync_fall)
            state_reg <= ams_pkg::ST_RUN;
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Active-time measurement and standby countdown in master clock ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meas_reg <= ams_pkg::MEAS_ZERO;
      rest_reg <= ams_pkg::REST_ZERO;
    end
    else if (state_reg == ams_pkg::ST_RUN)
    begin
      if (seq_done)
        rest_reg <= rest_load;
      else if (tick_next && (meas_reg != ams_pkg::MEAS_MAX))
        meas_reg <= meas_reg + 20'h00001;
    end
    else if (state_reg == ams_pkg::ST_REST)
    begin
      meas_reg <= ams_pkg::MEAS_ZERO;
      if (tick_next && (rest_reg != ams_pkg::REST_ZERO))
        rest_reg <= rest_reg - ams_pkg::REST_ONE;
    end
    else
      meas_reg <= ams_pkg::MEAS_ZERO;
  end

  // Core control outputs follow the state one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filter_hold <= 1'b1;
      conv_run <= 1'b0;
      low_power_hold <= 1'b0;
      power_down <= 1'b0;
      cal_active <= 1'b0;
      cal_select <= 2'h0;
    end
    else
    begin
      // Idle only resets filter and modulator; configuration is untouched
      filter_hold <= (state_reg != ams_pkg::ST_RUN) && (state_reg != ams_pkg::ST_CAL);
      conv_run <= (state_reg == ams_pkg::ST_RUN);
      low_power_hold <= (state_reg == ams_pkg::ST_LOW_POWER_HOLD)
                        || ((state_reg == ams_pkg::ST_REST) && (mode_reg != ams_pkg::MODE_SYNC_IDLE));
      power_down <= (state_reg == ams_pkg::ST_PDOWN);
      cal_active <= (state_reg == ams_pkg::ST_CAL);
      cal_select <= 2'(mode_reg - ams_pkg::MODE_CAL_INT_ZERO);
    end
  end

endmodule : ams_sequencer

`default_nettype wire

// *** dv/ams_sequencer_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

// Watches the sequencer outputs from the top-level ports only
module ams_sequencer_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read data channel
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Core handshake and control outputs
  input wire logic cal_done,
  input wire logic conv_run,
  input wire logic filter_hold,
  input wire logic low_power_hold,
  input wire logic power_down,
  input wire logic cal_active,
  // Clock pin and master tick
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic mclk_tick,
  input wire logic mclk_ext
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles the oscillator level has held so far
  logic [8:0] hold_cnt;
  // Oscillator level one cycle ago
  logic osc_prev;
  // Set once a full half period can be measured
  logic osc_seen;

  // Half period tracker; power-down may stop the oscillator, so it restarts there
  always_ff @(posedge aclk)
  begin
    osc_prev <= clk_pin_out;
    if (!aresetn || power_down)
    begin
      hold_cnt <= 9'h000;
      osc_seen <= 1'b0;
    end
    else if (clk_pin_out != osc_prev)
    begin
      hold_cnt <= 9'h001;
      osc_seen <= 1'b1;
    end
    else
      hold_cnt <= hold_cnt + 9'h001;
  end

  property p_pd_quiet;
    power_down |-> filter_hold && !conv_run && !cal_active && !low_power_hold;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("core active in power-down");
  property p_idle_hold;
    !conv_run && !cal_active |-> filter_hold;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("filter released while stopped");
  property p_cal_exit;
    cal_active && cal_done |-> ##[1:2] (!cal_active && filter_hold && !conv_run);
  endproperty
  a_cal_exit: assert property (p_cal_exit) else $error("calibration did not fall to idle");
  property p_cal_excl;
    cal_active |-> !filter_hold && !conv_run && !low_power_hold;
  endproperty
  a_cal_excl: assert property (p_cal_excl) else $error("calibration overlaps other state");
  property p_low_power_hold_excl;
    low_power_hold |-> filter_hold && !conv_run;
  endproperty
  a_low_power_hold_excl: assert property (p_low_power_hold_excl) else $error("standby while converting");
  property p_osc_half;
    osc_seen && (clk_pin_out != osc_prev) |-> hold_cnt == 9'(ams_pkg::OSC_HALF_CYC);
  endproperty
  a_osc_half: assert property (p_osc_half) else $error("oscillator half period wrong");
  property p_oe_int;
    clk_pin_oe |-> !mclk_ext;
  endproperty
  a_oe_int: assert property (p_oe_int) else $error("clock pin driven with external source");
  property p_tick_pulse;
    mclk_tick && !mclk_ext |=> !mclk_tick [*8];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("internal tick too frequent");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed while pending");
endmodule : ams_sequencer_asserts

bind ams_sequencer ams_sequencer_asserts i_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .cal_done(cal_done), .conv_run(conv_run), .filter_hold(filter_hold),
  .low_power_hold(low_power_hold), .power_down(power_down), .cal_active(cal_active),
  .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .mclk_tick(mclk_tick), .mclk_ext(mclk_ext)
);

`default_nettype wire

// *** dv/ams_sequencer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module ams_sequencer_tb;
  // Bus signals
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, cal_select;
  // Pins and core side; core_ev holds conv, seq and cal done pulses
  logic sync_n, clk_pin_in, clk_pin_out, clk_pin_oe, filter_hold, conv_run, low_power_hold;
  logic power_down, cal_active, mclk_tick, mclk_ext, hi;
  logic [2:0] core_ev;
  logic [23:0] conv_data;
  int error_cnt, cmp_count, cnt;

  ams_sequencer i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sync_n(sync_n), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .conv_done(core_ev[0]), .conv_data(conv_data), .seq_done(core_ev[1]), .cal_done(core_ev[2]),
    .filter_hold(filter_hold), .conv_run(conv_run), .low_power_hold(low_power_hold),
    .power_down(power_down), .cal_active(cal_active), .cal_select(cal_select),
    .mclk_tick(mclk_tick), .mclk_ext(mclk_ext)
  );

  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Single comparison point
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Write one word; each channel is released at its own handshake
  task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok || s_axi_awready === 1'b1;
      w_ok = w_ok || s_axi_wready === 1'b1;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(resp));
    // Mode outputs land two edges after the commit
    repeat (4) @(posedge aclk);
  endtask : wr

  // Read one word and compare data and response
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] resp);
    repeat (4) @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, exp);
    check("rresp", 32'(s_axi_rresp), 32'(resp));
  endtask : rd

  // Status register read
  task automatic st(input logic [31:0] exp);
    rd(ams_pkg::ADDR_STATUS, exp, ams_pkg::RESP_OKAY);
  endtask : st

  // Control write with internal clock shown on the pin; only defined mode codes come here
  task automatic set_mode(input logic [3:0] m, input logic r);
    wr(ams_pkg::ADDR_CTRL, {25'h0, r, m, 2'h1}, ams_pkg::RESP_OKAY);
  endtask : set_mode

  // One-cycle core event pulse
  task automatic pulse(input logic [2:0] ev);
    core_ev <= ev;
    @(posedge aclk);
    core_ev <= 3'h0;
  endtask : pulse

  // Hang guard, well above the expected run length
  initial
  begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    $display("ERROR watchdog expired");
    give_verdict();
  end

  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, core_ev, conv_data, clk_pin_in} = '0;
    s_axi_wstrb = 4'hf;
    sync_n = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(32'h00000041);
    rd(ams_pkg::ADDR_CTRL, 32'h0, ams_pkg::RESP_OKAY);
    rd(ams_pkg::ADDR_RESULT, 32'h0, ams_pkg::RESP_OKAY);
    rd(8'h0c, 32'h0, ams_pkg::RESP_SLVERR);
    wr(ams_pkg::ADDR_RESULT, 32'h00000055, ams_pkg::RESP_OKAY);
    rd(ams_pkg::ADDR_RESULT, 32'h0, ams_pkg::RESP_OKAY);
    wr(8'h10, 32'h0, ams_pkg::RESP_SLVERR);
    $display("test reset done");
    set_mode(ams_pkg::MODE_PDOWN, 1'b0);
    st(32'h00000041);
    rd(ams_pkg::ADDR_CTRL, 32'h1, ams_pkg::RESP_OKAY);
    set_mode(ams_pkg::MODE_STANDBY, 1'b0);
    set_mode(ams_pkg::MODE_PDOWN, 1'b0);
    st(32'h00000036);
    $display("test power-down done");
    // Each source; the pin makes eight rises then rests low
    for (int s = 0; s < 4; s++)
    begin
      wr(ams_pkg::ADDR_CTRL, {26'h0, ams_pkg::MODE_IDLE, 2'(s)}, ams_pkg::RESP_OKAY);
      check("clk_pin_oe", 32'(clk_pin_oe), 32'(s == 1));
      check("mclk_ext", 32'(mclk_ext), 32'(s > 1));
      cnt = 0;
      for (int i = 0; i < 400; i++)
      begin
        @(posedge aclk);
        cnt += (mclk_tick === 1'b1) ? 1 : 0;
        clk_pin_in <= (i % 40 < 20) && (i < 320);
      end
      if (s > 1)
        check("pin ticks", 32'(cnt), 32'((s == 2) ? 8 : 4));
    end
    $display("test clock select done");
    set_mode(ams_pkg::MODE_IDLE, 1'b0);
    st(32'h00000020);
    check("clk_pin_oe", 32'(clk_pin_oe), 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      set_mode(4'(ams_pkg::MODE_CAL_INT_ZERO + c), 1'b0);
      st(32'h00000082);
      check("cal_select", 32'(cal_select), 32'(c));
      pulse(3'h4);
      st(32'h00000020);
      rd(ams_pkg::ADDR_CTRL, 32'h11, ams_pkg::RESP_OKAY);
    end
    $display("test calibration done");
    conv_data <= 24'habcdef;
    pulse(3'h1);
    rd(ams_pkg::ADDR_RESULT, 32'h00abcdef, ams_pkg::RESP_OKAY);
    conv_data <= 24'h123456;
    pulse(3'h1);
    rd(ams_pkg::ADDR_RESULT, 32'h00123456, ams_pkg::RESP_OKAY);
    $display("test result done");
    // Single sequence runs once, then falls back to idle
    set_mode(ams_pkg::MODE_SINGLE, 1'b0);
    st(32'h00000041);
    pulse(3'h2);
    st(32'h00000020);
    // Two ticks of conversion, then count ticks spent in standby
    for (int r = 0; r < 2; r++)
    begin
      set_mode(ams_pkg::MODE_IDLE, 1'b0);
      // Start just after a tick so no tick is counted unseen during the write
      do @(posedge aclk); while (mclk_tick !== 1'b1);
      set_mode(ams_pkg::MODE_DUTY, 1'(r));
      repeat (2) do @(posedge aclk); while (mclk_tick !== 1'b1);
      pulse(3'h2);
      cnt = 0;
      hi = 1'b0;
      do
      begin
        @(posedge aclk);
        hi = hi || low_power_hold === 1'b1;
        cnt += (mclk_tick === 1'b1 && low_power_hold === 1'b1) ? 1 : 0;
      end
      while (!hi || low_power_hold === 1'b1);
      check("rest ticks", 32'(cnt), 32'(r ? 30 : 6));
      @(posedge aclk);
      check("rerun", 32'(conv_run), 32'h1);
    end
    $display("test duty cycle done");
    for (int m = 0; m < 2; m++)
    begin
      set_mode(4'(ams_pkg::MODE_SYNC_IDLE + m), 1'b0);
      check("wait standby", 32'(low_power_hold), 32'(m));
      sync_n <= 1'b0;
      repeat (4) @(posedge aclk);
      sync_n <= 1'b1;
      repeat (4) @(posedge aclk);
      check("sync run", 32'(conv_run), 32'h1);
      pulse(3'h2);
      repeat (4) @(posedge aclk);
      check("after run", 32'(conv_run), 32'h0);
      check("after standby", 32'(low_power_hold), 32'(m));
    end
    $display("test sync sequence done");
    give_verdict();
  end
endmodule : ams_sequencer_tb

`default_nettype wire
